//--- design/vjs_pkg.sv
package vjs_pkg;

  // Clock and timing
  localparam int CLK_KHZ         = 25000;
  localparam int PROG_CYCLE_US   = 1000;
  localparam int PROG_CYCLE_CLKS = PROG_CYCLE_US * CLK_KHZ / 1000;
  localparam int TRIP_HOLD_MS    = 20;
  localparam int ANGLE_SPAN_MS   = 20;
  localparam int TRIP_HOLD_TICKS = TRIP_HOLD_MS * 1000 / PROG_CYCLE_US;
  localparam int SPAN_TICKS      = ANGLE_SPAN_MS * 1000 / PROG_CYCLE_US;
  localparam int NUM_RECORDS     = 12;
  localparam int NUM_CH          = 4;
  localparam int DIV_STEPS       = 24;
  localparam logic [23:0] PU_SCALE = 24'h000064;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_TRIP_SET  = 8'h04;
  localparam logic [7:0] OFF_ALARM_SET = 8'h08;
  localparam logic [7:0] OFF_UV_LIMIT  = 8'h0C;
  localparam logic [7:0] OFF_MON_SEL   = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [7:0] OFF_CHG1      = 8'h18;
  localparam logic [7:0] OFF_RATIO1    = 8'h24;
  localparam logic [7:0] OFF_CNT_ALARM = 8'h30;
  localparam logic [7:0] OFF_CNT_TRIP  = 8'h34;
  localparam logic [7:0] OFF_CNT_BLOCK = 8'h38;
  localparam logic [7:0] OFF_REC_INFO  = 8'h3C;
  localparam logic [7:0] OFF_REC_SEL   = 8'h40;
  localparam logic [7:0] OFF_REC_W0    = 8'h44;
  localparam logic [7:0] OFF_REC_W1    = 8'h48;
  localparam logic [7:0] OFF_REC_W2    = 8'h4C;

  // Control register fields
  localparam int CTRL_ALARM_INCL = 0;
  localparam int CTRL_FILT_LSB   = 1;
  localparam int CTRL_FORCE_EN   = 3;
  localparam int CTRL_FORCED_LSB = 4;
  localparam int CTRL_CNT_CLR    = 6;

  // Values after reset
  localparam logic [15:0] RST_TRIP_SET  = 16'h01F4;
  localparam logic [15:0] RST_ALARM_SET = 16'h01F4;
  localparam logic [15:0] RST_UV_LIMIT  = 16'h251C;
  localparam logic [3:0]  RST_MON_SEL   = 4'h7;

  // Event filter settings
  localparam logic [1:0] FILT_ON_ONLY  = 2'h1;
  localparam logic [1:0] FILT_OFF_ONLY = 2'h2;
  localparam logic [5:0] MASK_ON       = 6'h15;
  localparam logic [5:0] MASK_OFF      = 6'h2A;

  typedef enum logic [1:0] {COND_NORMAL, COND_BLOCKED, COND_TRIP, COND_ALARM} vjs_cond_e;
  typedef enum logic [2:0] {EV_BLOCK_ON, EV_BLOCK_OFF, EV_TRIP_ON, EV_TRIP_OFF,
                            EV_ALARM_ON, EV_ALARM_OFF} vjs_event_e;

  // One operation record
  typedef struct packed {
    logic [47:0] stamp;
    logic [2:0]  code;
    logic [1:0]  ftype;
    logic [2:0]  group;
    logic [15:0] trip_diff;
    logic [15:0] alarm_diff;
  } vjs_rec_s;

endpackage : vjs_pkg

//--- design/vjs_rec_mem.sv
`timescale 1ns/100ps
`default_nettype none
module vjs_rec_mem #(
  parameter int WIDTH = 88,
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic             hclk,    // System clock
  input  wire logic             hresetn, // Async reset, active low
  input  wire logic             wr_en,   // Write strobe
  input  wire logic [AW-1:0]    wr_addr, // Write slot
  input  wire logic [WIDTH-1:0] wr_data, // Write data
  input  wire logic [AW-1:0]    rd_addr, // Read slot
  output logic      [WIDTH-1:0] rd_data  // Registered read data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } vjs_mem_s;

  vjs_mem_s s_q;
  vjs_mem_s s_d;

  // Write port and registered read
  always_comb begin
    s_d = s_q;
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      s_d.mem[wr_addr] = wr_data;
    end
    s_d.rd = (int'(rd_addr) < DEPTH) ? s_q.mem[rd_addr] : '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd;

endmodule : vjs_rec_mem
`default_nettype wire

//--- design/vjs_top.sv
// Summary of operation
// - Stage status is normal, blocked, trip or alarm
// - Report whether monitored channel selection is valid
// - Report angle change over 20 ms, channels 1-3
// - Report voltage to undervoltage limit ratio
// - Sample blocking input once per program cycle
// - Unblocked pick-up asserts trip or alarm
// - Blocked pick-up asserts blocked, nothing else
// - Six events on blocked, trip, alarm edges
// - Filter events: ON only, OFF only, both
// - Every event carries a time stamp
// - Clearable counters of alarm, trip, blocked
// - Twelve records, newest overwrites the oldest
// - Record made only on ON events
// - Record: time, event, fault type, angles, group
// - Stage outputs available for I/O and logic
// - Trip output held 20 ms, then self-releases
// - Undervoltage on monitored channel blocks the stage
// - Alarm generated only when alarm is included
// - Forcing drives status to the forced value
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module vjs_top #(
  parameter int PROG_CYCLE_CLKS = vjs_pkg::PROG_CYCLE_CLKS
) (
  input  wire logic             hclk,          // System clock, 25 MHz
  input  wire logic             hresetn,       // Async reset, active low
  input  wire logic             hsel,          // Slave select
  input  wire logic [31:0]      haddr,         // Byte address
  input  wire logic             hwrite,        // Write when high
  input  wire logic [1:0]       htrans,        // Transfer type
  input  wire logic [2:0]       hsize,         // Word transfers only
  input  wire logic             hready,        // Bus ready
  input  wire logic [31:0]      hwdata,        // Write data
  output logic      [31:0]      hrdata,        // Read data
  output logic                  hreadyout,     // Slave ready
  output logic                  hresp,         // Always OKAY
  input  wire logic [3:0][15:0] ch_angle,      // Angle per channel, 0.01 deg
  input  wire logic [3:0][15:0] ch_volt,       // Voltage per channel, 0.01 %Un
  input  wire logic             block_in,      // Blocking matrix input
  input  wire logic [47:0]      time_ms,       // Wall time in ms
  input  wire logic [2:0]       setting_group, // Active setting group
  output logic                  trip_out,      // Stage trip
  output logic                  alarm_out,     // Stage alarm
  output logic                  blocked_out,   // Stage blocked
  output logic                  evt_valid,     // Event strobe
  output logic      [2:0]       evt_code,      // Event type
  output logic      [47:0]      evt_stamp      // Event time stamp
);

  localparam int CW  = $clog2(PROG_CYCLE_CLKS + 1);
  localparam int RW  = $bits(vjs_pkg::vjs_rec_s);

  typedef struct packed {
    logic                 alarm_incl;
    logic [1:0]           filt;
    logic                 force_en;
    logic [1:0]           forced;
    logic [15:0]          trip_set;
    logic [15:0]          alarm_set;
    logic [15:0]          uv_lim;
    logic [3:0]           mon;
    logic [3:0]           rec_sel;
    logic                 dph;
    logic                 dwr;
    logic [7:0]           daddr;
    logic                 rdy;
    logic [31:0]          rdata;
    logic [CW-1:0]        pc_cnt;
    logic [4:0]           span_cnt;
    logic                 blk_smp;
    logic [3:0][15:0]     snap;
    logic [3:0][16:0]     chg;
    logic [2:0][15:0]     ratio;
    logic [1:0]           dch;
    logic [4:0]           dcnt;
    logic                 dbusy;
    logic [23:0]          dnum;
    logic [16:0]          drem;
    logic [23:0]          dquo;
    logic                 trip;
    logic                 alarm;
    logic                 blocked;
    logic [4:0]           hold;
    logic [1:0]           cond;
    logic                 sel_ok;
    logic [5:0]           pend;
    logic                 ev_v;
    logic [2:0]           ev_code;
    logic [47:0]          ev_stamp;
    logic [2:0][15:0]     cnt;
    logic [3:0]           wptr;
    logic [3:0]           rcount;
    logic                 rec_we;
    logic [3:0]           rec_wa;
    vjs_pkg::vjs_rec_s    rec;
  } vjs_state_s;

  vjs_state_s        s_q;
  vjs_state_s        s_d;
  vjs_pkg::vjs_rec_s rec_rd;
  logic [RW-1:0]     rec_rd_raw;
  logic              tick;
  logic              pk_trip;
  logic              pk_alarm;
  logic              uv;
  logic              blk;
  logic [16:0]       mag;
  logic [16:0]       max_mag;
  logic [1:0]        max_ch;
  logic [5:0]        new_ev;
  logic [5:0]        ev_mask;
  logic [16:0]       dtry;
  logic [31:0]       rmux;

  // Record store, read data registered
  vjs_rec_mem #(
    .WIDTH (RW),
    .DEPTH (vjs_pkg::NUM_RECORDS),
    .AW    (4)
  ) u_rec_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (s_q.rec_we),
    .wr_addr (s_q.rec_wa),
    .wr_data (s_q.rec),
    .rd_addr (s_q.rec_sel),
    .rd_data (rec_rd_raw)
  );

  assign rec_rd = vjs_pkg::vjs_rec_s'(rec_rd_raw);

  // Next-state logic of the whole block
  always_comb begin
    s_d      = s_q;
    tick     = (s_q.pc_cnt == '0);
    pk_trip  = 1'b0;
    pk_alarm = 1'b0;
    uv       = 1'b0;
    mag      = '0;
    max_mag  = '0;
    max_ch   = 2'h0;
    new_ev   = '0;
    ev_mask  = '1;
    dtry     = '0;
    rmux     = '0;

    // Program cycle divider
    s_d.pc_cnt = tick ? CW'(PROG_CYCLE_CLKS - 1) : s_q.pc_cnt - CW'(1);

    // Angle change over one 20 ms span
    if (tick) begin
      s_d.span_cnt = (s_q.span_cnt == '0) ? 5'(vjs_pkg::SPAN_TICKS - 1) : s_q.span_cnt - 5'h01;
    end
    for (int i = 0; i < vjs_pkg::NUM_CH; i++) begin
      if (tick && s_q.span_cnt == '0) begin
        s_d.chg[i]  = {1'b0, ch_angle[i]} - {1'b0, s_q.snap[i]};
        s_d.snap[i] = ch_angle[i];
      end
      mag = s_q.chg[i][16] ? 17'(-s_q.chg[i]) : s_q.chg[i];
      if (s_q.mon[i]) begin
        if (mag >= {1'b0, s_q.trip_set}) pk_trip = 1'b1;
        if (mag >= {1'b0, s_q.alarm_set}) pk_alarm = 1'b1;
        if (ch_volt[i] < s_q.uv_lim) uv = 1'b1;
        if (mag > max_mag) begin
          max_mag = mag;
          max_ch  = 2'(i);
        end
      end
    end

    // Voltage ratio by serial division, one channel after another
    if (s_q.dbusy) begin
      dtry = {s_q.drem[15:0], s_q.dnum[23]};
      s_d.dnum = {s_q.dnum[22:0], 1'b0};
      if (dtry >= {1'b0, s_q.uv_lim}) begin
        s_d.drem = dtry - {1'b0, s_q.uv_lim};
        s_d.dquo = {s_q.dquo[22:0], 1'b1};
      end else begin
        s_d.drem = dtry;
        s_d.dquo = {s_q.dquo[22:0], 1'b0};
      end
      s_d.dcnt = s_q.dcnt - 5'h01;
      if (s_q.dcnt == 5'h01) begin
        s_d.ratio[s_q.dch] = (s_q.uv_lim == '0 || s_d.dquo[23:16] != '0) ? 16'hFFFF : s_d.dquo[15:0];
        s_d.dbusy = (s_q.dch != 2'h2);
        s_d.dch   = s_q.dch + 2'h1;
        s_d.dnum  = {8'h00, ch_volt[s_q.dch + 2'h1]} * vjs_pkg::PU_SCALE;
        s_d.drem  = '0;
        s_d.dquo  = '0;
        s_d.dcnt  = 5'(vjs_pkg::DIV_STEPS);
      end
    end else if (tick) begin
      s_d.dbusy = 1'b1;
      s_d.dch   = 2'h0;
      s_d.dnum  = {8'h00, ch_volt[0]} * vjs_pkg::PU_SCALE;
      s_d.drem  = '0;
      s_d.dquo  = '0;
      s_d.dcnt  = 5'(vjs_pkg::DIV_STEPS);
    end

    // Stage evaluation once per program cycle
    s_d.sel_ok = (s_q.mon != '0);
    pk_alarm   = pk_alarm & s_q.alarm_incl & s_d.sel_ok;
    pk_trip    = pk_trip & s_d.sel_ok;
    if (tick) begin
      s_d.blk_smp = block_in;
      blk         = block_in | uv;
      s_d.blocked = (pk_trip | pk_alarm) & blk;
      s_d.alarm   = pk_alarm & ~blk;
      if (pk_trip && !blk) begin
        s_d.trip = 1'b1;
        s_d.hold = 5'(vjs_pkg::TRIP_HOLD_TICKS - 1);
      end else if (s_q.trip) begin
        if (s_q.hold == '0) s_d.trip = 1'b0;
        else s_d.hold = s_q.hold - 5'h01;
      end
    end else begin
      blk = s_q.blk_smp | uv;
    end

    // Status, forced value when forcing is on
    if (s_q.force_en) s_d.cond = s_q.forced;
    else if (s_d.trip) s_d.cond = vjs_pkg::COND_TRIP;
    else if (s_d.alarm) s_d.cond = vjs_pkg::COND_ALARM;
    else if (s_d.blocked) s_d.cond = vjs_pkg::COND_BLOCKED;
    else s_d.cond = vjs_pkg::COND_NORMAL;

    // Edge events, filtered before queueing
    new_ev = {~s_d.alarm & s_q.alarm, s_d.alarm & ~s_q.alarm,
              ~s_d.trip & s_q.trip, s_d.trip & ~s_q.trip,
              ~s_d.blocked & s_q.blocked, s_d.blocked & ~s_q.blocked};
    if (s_q.filt == vjs_pkg::FILT_ON_ONLY) ev_mask = vjs_pkg::MASK_ON;
    else if (s_q.filt == vjs_pkg::FILT_OFF_ONLY) ev_mask = vjs_pkg::MASK_OFF;

    // Emit one queued event per cycle, lowest code first
    s_d.ev_v = 1'b0;
    for (int i = 5; i >= 0; i--) begin
      if (s_q.pend[i]) s_d.ev_code = 3'(i);
    end
    if (s_q.pend != '0) begin
      s_d.ev_v     = 1'b1;
      s_d.ev_stamp = time_ms;
      s_d.pend[s_d.ev_code] = 1'b0;
    end
    s_d.pend = s_d.pend | (new_ev & ev_mask);

    // Occurrence counters, increment wins over clear
    for (int i = 0; i < 3; i++) begin
      s_d.cnt[i] = s_q.cnt[i] + 16'(new_ev[2 * i]);
    end

    // Operation record on ON edges only
    s_d.rec_we = new_ev[0] | new_ev[2] | new_ev[4];
    s_d.rec_wa = s_q.wptr;
    if (s_d.rec_we) begin
      s_d.rec.stamp      = time_ms;
      s_d.rec.code       = new_ev[2] ? vjs_pkg::EV_TRIP_ON :
                           (new_ev[4] ? vjs_pkg::EV_ALARM_ON : vjs_pkg::EV_BLOCK_ON);
      s_d.rec.ftype      = max_ch;
      s_d.rec.group      = setting_group;
      s_d.rec.trip_diff  = max_mag[15:0];
      s_d.rec.alarm_diff = s_q.alarm_incl ? max_mag[15:0] : '0;
      s_d.wptr = (s_q.wptr == 4'(vjs_pkg::NUM_RECORDS - 1)) ? '0 : s_q.wptr + 4'h1;
      if (s_q.rcount != 4'(vjs_pkg::NUM_RECORDS)) s_d.rcount = s_q.rcount + 4'h1;
    end

    // Register read mux
    unique case (s_q.daddr)
      vjs_pkg::OFF_CTRL:      rmux = {26'h0, s_q.forced, s_q.force_en, s_q.filt, s_q.alarm_incl};
      vjs_pkg::OFF_TRIP_SET:  rmux = {16'h0, s_q.trip_set};
      vjs_pkg::OFF_ALARM_SET: rmux = {16'h0, s_q.alarm_set};
      vjs_pkg::OFF_UV_LIMIT:  rmux = {16'h0, s_q.uv_lim};
      vjs_pkg::OFF_MON_SEL:   rmux = {28'h0, s_q.mon};
      vjs_pkg::OFF_STATUS:    rmux = {25'h0, s_q.blk_smp, s_q.alarm, s_q.trip, s_q.blocked,
                                      s_q.sel_ok, s_q.cond};
      vjs_pkg::OFF_CNT_ALARM: rmux = {16'h0, s_q.cnt[2]};
      vjs_pkg::OFF_CNT_TRIP:  rmux = {16'h0, s_q.cnt[1]};
      vjs_pkg::OFF_CNT_BLOCK: rmux = {16'h0, s_q.cnt[0]};
      vjs_pkg::OFF_REC_INFO:  rmux = {20'h0, s_q.wptr, 4'h0, s_q.rcount};
      vjs_pkg::OFF_REC_SEL:   rmux = {28'h0, s_q.rec_sel};
      vjs_pkg::OFF_REC_W0:    rmux = rec_rd.stamp[31:0];
      vjs_pkg::OFF_REC_W1:    rmux = {5'h0, rec_rd.group, 2'h0, rec_rd.ftype, 1'b0, rec_rd.code,
                                      rec_rd.stamp[47:32]};
      vjs_pkg::OFF_REC_W2:    rmux = {rec_rd.alarm_diff, rec_rd.trip_diff};
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (s_q.daddr == vjs_pkg::OFF_CHG1 + 8'(4 * i)) rmux = {{15{s_q.chg[i][16]}}, s_q.chg[i]};
          if (s_q.daddr == vjs_pkg::OFF_RATIO1 + 8'(4 * i)) rmux = {16'h0, s_q.ratio[i]};
        end
      end
    endcase

    // Bus slave: one wait state, access in first data cycle
    if (s_q.dph) begin
      s_d.dph = 1'b0;
      s_d.rdy = 1'b1;
      if (s_q.dwr) begin
        unique case (s_q.daddr)
          vjs_pkg::OFF_CTRL: begin
            s_d.alarm_incl = hwdata[vjs_pkg::CTRL_ALARM_INCL];
            s_d.filt       = hwdata[vjs_pkg::CTRL_FILT_LSB +: 2];
            s_d.force_en   = hwdata[vjs_pkg::CTRL_FORCE_EN];
            s_d.forced     = hwdata[vjs_pkg::CTRL_FORCED_LSB +: 2];
            if (hwdata[vjs_pkg::CTRL_CNT_CLR]) begin
              for (int i = 0; i < 3; i++) s_d.cnt[i] = 16'(new_ev[2 * i]);
            end
          end
          vjs_pkg::OFF_TRIP_SET:  s_d.trip_set  = hwdata[15:0];
          vjs_pkg::OFF_ALARM_SET: s_d.alarm_set = hwdata[15:0];
          vjs_pkg::OFF_UV_LIMIT:  s_d.uv_lim    = hwdata[15:0];
          vjs_pkg::OFF_MON_SEL:   s_d.mon       = hwdata[3:0];
          vjs_pkg::OFF_REC_SEL:   s_d.rec_sel   = hwdata[3:0];
          default: ;
        endcase
      end else begin
        s_d.rdata = rmux;
      end
    end else if (hsel && htrans[1] && hready) begin
      s_d.dph   = 1'b1;
      s_d.rdy   = 1'b0;
      s_d.dwr   = hwrite;
      s_d.daddr = (haddr[31:8] == '0 && haddr[1:0] == 2'h0) ? haddr[7:0] : 8'hFF;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.trip_set  <= vjs_pkg::RST_TRIP_SET;
      s_q.alarm_set <= vjs_pkg::RST_ALARM_SET;
      s_q.uv_lim    <= vjs_pkg::RST_UV_LIMIT;
      s_q.mon       <= vjs_pkg::RST_MON_SEL;
      s_q.rdy       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign hrdata      = s_q.rdata;
  assign hreadyout   = s_q.rdy;
  assign hresp       = s_q.dwr & 1'b0;
  assign trip_out    = s_q.trip;
  assign alarm_out   = s_q.alarm;
  assign blocked_out = s_q.blocked;
  assign evt_valid   = s_q.ev_v;
  assign evt_code    = s_q.ev_code;
  assign evt_stamp   = s_q.ev_stamp;

endmodule : vjs_top
`default_nettype wire

//--- bench/vjs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module vjs_checker #(
  parameter int PROG_CYCLE_CLKS = vjs_pkg::PROG_CYCLE_CLKS
) (
  input wire logic        hclk,        // Clock
  input wire logic        hresetn,     // Reset, active low
  input wire logic        hsel,        // Select
  input wire logic        hwrite,      // Write
  input wire logic [1:0]  htrans,      // Transfer type
  input wire logic        hready,      // Bus ready
  input wire logic [31:0] hrdata,      // Read data
  input wire logic        hreadyout,   // Slave ready
  input wire logic        hresp,       // Response
  input wire logic [47:0] time_ms,     // Wall time
  input wire logic        trip_out,    // Trip
  input wire logic        alarm_out,   // Alarm
  input wire logic        blocked_out, // Blocked
  input wire logic        evt_valid,   // Event strobe
  input wire logic [2:0]  evt_code,    // Event type
  input wire logic [47:0] evt_stamp    // Event stamp
);
  localparam int HOLD = vjs_pkg::TRIP_HOLD_TICKS * PROG_CYCLE_CLKS;
  int   pc_q;
  int   trip_n_q;
  logic rd_ph_q;

  // Tick phase, trip length and read data phase trackers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q     <= 0;
      trip_n_q <= 0;
      rd_ph_q  <= 1'b0;
    end else begin
      pc_q     <= (pc_q == PROG_CYCLE_CLKS - 1) ? 0 : pc_q + 1;
      trip_n_q <= trip_out ? trip_n_q + 1 : 0;
      if (hsel && htrans[1] && hready) begin
        rd_ph_q <= !hwrite;
      end else if (hreadyout) begin
        rd_ph_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_take;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_wait_then_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_BUS_WAIT: assert property (s_take |=> s_wait_then_ready)
    else $error("bus wait state wrong");
  AST_READY_BACK: assert property (!hreadyout |=> hreadyout)
    else $error("ready low too long");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_HRDATA_HOLD: assert property ($changed(hrdata) |-> rd_ph_q)
    else $error("read data moved outside read");
  AST_OUT_AT_TICK: assert property ($changed({trip_out, alarm_out, blocked_out}) |-> pc_q == 1)
    else $error("outputs moved off tick");
  AST_EVT_WIN: assert property (evt_valid |-> pc_q inside {[2:7]})
    else $error("event outside tick window");
  AST_EVT_CODE: assert property (evt_valid |-> evt_code <= 3'h5)
    else $error("bad event code");
  AST_EVT_STAMP: assert property (evt_valid |-> evt_stamp == time_ms || evt_stamp == $past(time_ms))
    else $error("event stamp wrong");
  AST_TRIP_HOLD: assert property ($fell(trip_out) |-> trip_n_q >= HOLD)
    else $error("trip released early");
  AST_TRIP_CLEAR: assert property ($rose(trip_out) |-> !blocked_out)
    else $error("trip while blocked");
  AST_BLOCK_ALONE: assert property ($rose(blocked_out) |-> !$rose(trip_out) && !$rose(alarm_out))
    else $error("blocked pick-up went on");
endmodule : vjs_checker

bind vjs_top vjs_checker #(.PROG_CYCLE_CLKS(PROG_CYCLE_CLKS)) vjs_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .htrans(htrans),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .time_ms(time_ms),
  .trip_out(trip_out), .alarm_out(alarm_out), .blocked_out(blocked_out),
  .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp));
`default_nettype wire

//--- bench/vjs_partner.sv
`timescale 1ns/100ps
`default_nettype none
module vjs_partner #(
  parameter int MS_CLKS = 100
) (
  input  wire logic        hclk,      // Clock
  input  wire logic        hresetn,   // Reset, active low
  input  wire logic        block_req, // Block wanted by bench
  input  wire logic        evt_valid, // Event strobe
  input  wire logic [2:0]  evt_code,  // Event type
  output logic             block_in,  // Blocking matrix output
  output logic      [47:0] time_ms    // Wall time
);
  int ev_q[$];
  int div;

  // Blocking matrix, wall clock and event buffer intake
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_in <= 1'b0;
      time_ms  <= 48'h0;
      div      <= 0;
    end else begin
      block_in <= block_req;
      div      <= (div == MS_CLKS - 1) ? 0 : div + 1;
      if (div == MS_CLKS - 1) time_ms <= time_ms + 48'h1;
      if (evt_valid === 1'b1) ev_q.push_back(int'(evt_code));
    end
  end
endmodule : vjs_partner
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int P = 100;
  logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, block_req = 1'b0;
  logic             block_in, trip_out, alarm_out, blocked_out, evt_valid, hreadyout, hresp;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]       htrans = 2'h0;
  logic [2:0]       hsize = 3'h2, grp = 3'h5, evt_code;
  logic [15:0]      ang = 16'h0000;
  logic [3:0][15:0] ch_angle = '0, ch_volt = {4{16'h2710}};
  logic [47:0]      time_ms, evt_stamp;
  wire logic        hready;
  int               failures = 0, check_count = 0, cyc = 0, seed = 7, lim, ca, ct, cb, nrec, exp_q[$];

  // Clock and bus ready loop
  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  vjs_top #(.PROG_CYCLE_CLKS(P)) vjs_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ch_angle(ch_angle), .ch_volt(ch_volt), .block_in(block_in), .time_ms(time_ms),
    .setting_group(grp), .trip_out(trip_out), .alarm_out(alarm_out), .blocked_out(blocked_out),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp));
  vjs_partner #(.MS_CLKS(P)) vjs_partner_inst (
    .hclk(hclk), .hresetn(hresetn), .block_req(block_req), .evt_valid(evt_valid),
    .evt_code(evt_code), .block_in(block_in), .time_ms(time_ms));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rc

  task automatic wait_out(input logic [2:0] m, input logic [2:0] v);
    int n;
    n = 0;
    while ((({blocked_out, alarm_out, trip_out} & m) !== v) && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n < 5000), 32'h1);
  endtask : wait_out

  // Toggle channel one by a jump of six degrees
  task automatic step;
    ang = (ang == 16'h0000) ? 16'h0258 : 16'h0000;
    @(posedge hclk);
    ch_angle[0] <= ang;
  endtask : step

  task automatic chk_evs;
    int g, e;
    repeat (10) @(posedge hclk);
    while (exp_q.size() > 0 || vjs_partner_inst.ev_q.size() > 0) begin
      g = (vjs_partner_inst.ev_q.size() > 0) ? vjs_partner_inst.ev_q.pop_front() : 255;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 255;
      chk(g, e);
    end
  endtask : chk_evs

  task finish_test;
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Watchdog on total run length
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      finish_test;
    end
  end

  initial begin
    ch_volt[1] <= 16'(16'h251C + ($random(seed) & 32'hFFF));
    ch_volt[2] <= 16'(16'h251C + ($random(seed) & 32'hFFF));
    lim = int'(vjs_pkg::RST_UV_LIMIT);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, status and unmapped space
    rc(vjs_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    rc(vjs_pkg::OFF_TRIP_SET, 32'hFFFF, 32'h01F4);
    rc(vjs_pkg::OFF_ALARM_SET, 32'hFFFF, 32'h01F4);
    rc(vjs_pkg::OFF_UV_LIMIT, 32'hFFFF, 32'h251C);
    rc(vjs_pkg::OFF_MON_SEL, 32'hF, 32'h7);
    rc(vjs_pkg::OFF_STATUS, 32'h7F, 32'h4);
    ahb(1'b1, 8'h80, 32'hFFFFFFFF);
    rc(8'h80, 32'hFFFFFFFF, 32'h0);
    repeat (2 * P) @(posedge hclk);
    for (int i = 0; i < 3; i++) rc(vjs_pkg::OFF_RATIO1 + 8'(4 * i), 32'hFFFF, 32'(ch_volt[i] * 100 / lim));
    $display("test registers done");
    // Trip with alarm
    ahb(1'b1, vjs_pkg::OFF_CTRL, 32'h1);
    step;
    wait_out(3'h3, 3'h3);
    rc(vjs_pkg::OFF_STATUS, 32'h3B, 32'h32);
    rc(vjs_pkg::OFF_CHG1, 32'hFFFFFFFF, 32'h258);
    wait_out(3'h1, 3'h0);
    exp_q = {2, 4, 5, 3};
    chk_evs;
    ca = 1;
    ct = 1;
    nrec = 1;
    rc(vjs_pkg::OFF_REC_INFO, 32'hF, 32'(nrec));
    ahb(1'b1, vjs_pkg::OFF_REC_SEL, 32'h0);
    repeat (2) @(posedge hclk);
    rc(vjs_pkg::OFF_REC_W1, 32'h07370000, 32'h05020000);
    rc(vjs_pkg::OFF_REC_W2, 32'hFFFFFFFF, 32'h02580258);
    $display("test trip alarm done");
    // Blocked pick-up under each event filter
    for (int f = 1; f < 4; f++) begin
      ahb(1'b1, vjs_pkg::OFF_CTRL, 32'(f << 1));
      block_req <= 1'b1;
      repeat (2 * P) @(posedge hclk);
      step;
      wait_out(3'h4, 3'h4);
      chk(32'(trip_out), 32'h0);
      wait_out(3'h4, 3'h0);
      block_req <= 1'b0;
      if (f != 2) exp_q.push_back(0);
      if (f != 1) exp_q.push_back(1);
      chk_evs;
      cb++;
      nrec++;
    end
    $display("test blocking filters done");
    // Trip only, alarm left out
    ahb(1'b1, vjs_pkg::OFF_CTRL, 32'h0);
    step;
    wait_out(3'h1, 3'h1);
    chk(32'(alarm_out), 32'h0);
    wait_out(3'h1, 3'h0);
    exp_q = {2, 3};
    chk_evs;
    ct++;
    nrec++;
    // Counters and their clearing
    rc(vjs_pkg::OFF_CNT_ALARM, 32'hFFFF, 32'(ca));
    rc(vjs_pkg::OFF_CNT_TRIP, 32'hFFFF, 32'(ct));
    rc(vjs_pkg::OFF_CNT_BLOCK, 32'hFFFF, 32'(cb));
    ahb(1'b1, vjs_pkg::OFF_CTRL, 32'h40);
    for (int i = 0; i < 3; i++) rc(vjs_pkg::OFF_CNT_ALARM + 8'(4 * i), 32'hFFFF, 32'h0);
    $display("test trip only and counters done");
    // Forced status values
    for (int v = 0; v < 4; v++) begin
      ahb(1'b1, vjs_pkg::OFF_CTRL, 32'(8 | (v << 4)));
      rc(vjs_pkg::OFF_STATUS, 32'h3, 32'(v));
    end
    ahb(1'b1, vjs_pkg::OFF_CTRL, 32'h0);
    // Undervoltage blocking
    ch_volt[0] <= 16'h0064;
    step;
    wait_out(3'h4, 3'h4);
    chk(32'(trip_out), 32'h0);
    rc(vjs_pkg::OFF_RATIO1, 32'hFFFF, 32'(100 * 100 / lim));
    wait_out(3'h4, 3'h0);
    ch_volt[0] <= 16'h2710;
    exp_q = {0, 1};
    chk_evs;
    nrec++;
    rc(vjs_pkg::OFF_CNT_BLOCK, 32'hFFFF, 32'h1);
    rc(vjs_pkg::OFF_REC_INFO, 32'hF, 32'(nrec));
    // Record wrap
    block_req <= 1'b1;
    repeat (7) begin
      step;
      wait_out(3'h4, 3'h4);
      wait_out(3'h4, 3'h0);
      exp_q.push_back(0);
      exp_q.push_back(1);
    end
    block_req <= 1'b0;
    chk_evs;
    rc(vjs_pkg::OFF_REC_INFO, 32'hF0F, 32'h10C);
    $display("test undervoltage and wrap done");
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
